/* fseq_host.v */
// host sequencer that reads, programs and erases the four-device flash module
`timescale 1ns/1ps
`include "fseq_defines.vh"

module fseq_host #(
  parameter AW              = 17,
  parameter DW              = 16,
  parameter TW              = 20,
  parameter ERASE_CYCLES    = `FSEQ_TDE_MIN_CYC,
  parameter CMD_ERASE_SETUP = 8'h01,
  parameter CMD_ERASE_GO    = 8'h02,
  parameter CMD_PROG_VERIFY = 8'h03,
  parameter CMD_ERASE_VERIFY = 8'h04
) (
  input  wire          mclk_i,
  input  wire          resetn_i,
  input  wire          cmd_valid_i,
  input  wire [1:0]    cmd_op_i,
  input  wire          cmd_bank_i,
  input  wire [1:0]    cmd_lanes_i,
  input  wire [AW-1:0] cmd_addr_i,
  input  wire [DW-1:0] cmd_data_i,
  output reg           cmd_ready_o,
  output reg           done_o,
  output reg  [DW-1:0] rdata_o,
  output reg  [AW-1:0] flash_addr_o,
  output reg  [DW-1:0] flash_dq_o,
  output reg           flash_dq_oe_o,
  input  wire [DW-1:0] flash_dq_i,
  output reg  [3:0]    device_selects_n_o,
  output reg           write_en_n_o,
  output reg           output_en_n_o,
  output reg           vpp_high_o
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_VPP  = 4'h1;
  localparam S_WSEL = 4'h2;
  localparam S_WPUL = 4'h3;
  localparam S_WHLD = 4'h4;
  localparam S_WNXT = 4'h5;
  localparam S_OPW  = 4'h6;
  localparam S_RCV  = 4'h7;
  localparam S_RACC = 4'h8;
  localparam S_RFLT = 4'h9;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // command byte on targeted lanes, null byte elsewhere
  function [15:0] fseq_lane_word;
    input [7:0] cmd;
    input [1:0] lanes;
    begin
      fseq_lane_word = {(lanes[1] ? cmd : `FSEQ_CMD_NULL),
                        (lanes[0] ? cmd : `FSEQ_CMD_NULL)};
    end
  endfunction

  // active-low selects: devices 0/2 on the low lane, 1/3 on the high lane
  function [3:0] fseq_sel_n;
    input       bank;
    input [1:0] lanes;
    begin
      fseq_sel_n = bank ? ~{lanes, 2'b00} : ~{2'b00, lanes};
    end
  endfunction

  // word for write number step of the current operation
  function [15:0] fseq_wr_word;
    input [1:0]  op;
    input [1:0]  step;
    input [1:0]  lanes;
    input [15:0] data;
    begin
      if (op == `FSEQ_OP_PROGRAM) begin
        case (step)
          2'h0:    fseq_wr_word = fseq_lane_word(`FSEQ_CMD_PROG_SETUP, lanes);
          2'h1:    fseq_wr_word = data;
          default: fseq_wr_word = fseq_lane_word(CMD_PROG_VERIFY, lanes);
        endcase
      end else begin
        case (step)
          2'h0:    fseq_wr_word = fseq_lane_word(CMD_ERASE_SETUP, lanes);
          2'h1:    fseq_wr_word = fseq_lane_word(CMD_ERASE_GO, lanes);
          default: fseq_wr_word = fseq_lane_word(CMD_ERASE_VERIFY, lanes);
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  reg rst_meta;
  reg rst_n;

  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // wait timer
  // ----------------------------------------------------------------------
  reg          tmr_load;
  reg [31:0]   tmr_count;
  wire         tmr_zero;
  wire         tmr_done;

  fseq_timer #(
    .WIDTH (TW)
  ) i_fseq_timer (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n),
    .load_i  (tmr_load),
    .count_i (tmr_count[TW-1:0]),    // counts are integers, cut to timer width
    .zero_o  (tmr_zero)
  );

  // a load still in flight blocks the stale zero of the last wait
  assign tmr_done = tmr_zero & ~tmr_load;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  reg [3:0]    state;
  reg [1:0]    op;
  reg          bank;
  reg [1:0]    lanes;
  reg [DW-1:0] data;
  reg [1:0]    step;

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state              <= S_IDLE;
      op                 <= `FSEQ_OP_READ;
      bank               <= 1'b0;
      lanes              <= 2'b00;
      data               <= {DW{1'b0}};
      step               <= 2'h0;
      tmr_load           <= 1'b0;
      tmr_count          <= 32'h00000000;
      cmd_ready_o        <= 1'b0;
      done_o             <= 1'b0;
      rdata_o            <= {DW{1'b0}};
      flash_addr_o       <= {AW{1'b0}};
      flash_dq_o         <= {DW{1'b0}};
      flash_dq_oe_o      <= 1'b0;
      device_selects_n_o <= 4'hF;
      write_en_n_o       <= 1'b1;
      output_en_n_o      <= 1'b1;
      vpp_high_o         <= 1'b0;
    end else begin
      tmr_load <= 1'b0;
      done_o   <= 1'b0;
      case (state)
        S_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o  <= 1'b0;
            op           <= cmd_op_i;
            bank         <= cmd_bank_i;
            lanes        <= cmd_lanes_i;
            data         <= cmd_data_i;
            step         <= 2'h0;
            flash_addr_o <= cmd_addr_i;
            tmr_load     <= 1'b1;
            if (cmd_op_i == `FSEQ_OP_READ) begin
              // plain read at low supply, only the targeted devices
              device_selects_n_o <= fseq_sel_n(cmd_bank_i, cmd_lanes_i);
              output_en_n_o      <= 1'b0;
              tmr_count          <= `FSEQ_TACC_CYC;
              state              <= S_RACC;
            end else begin
              vpp_high_o <= 1'b1;
              tmr_count  <= `FSEQ_SUPPLY_TO_SELECT_GAP_CYC;
              state      <= S_VPP;
            end
          end
        end
        S_VPP: begin
          // no select drops before the supply has settled
          if (tmr_done) begin
            state <= S_WSEL;
          end
        end
        S_WSEL: begin
          // both devices of the bank see the word; non-targets get 00H in command words
          device_selects_n_o <= fseq_sel_n(bank, 2'b11);
          flash_dq_o         <= fseq_wr_word(op, step, lanes, data);
          flash_dq_oe_o      <= 1'b1;
          state              <= S_WPUL;
        end
        S_WPUL: begin
          // selects lead the write strobe, so write enable sets the window
          if (write_en_n_o) begin
            write_en_n_o <= 1'b0;
            tmr_load     <= 1'b1;
            tmr_count    <= `FSEQ_TWP_CYC;
          end else if (tmr_done) begin
            write_en_n_o <= 1'b1;
            state        <= S_WHLD;
          end
        end
        S_WHLD: begin
          // data held one cycle past the rising strobe, then all released
          device_selects_n_o <= 4'hF;
          flash_dq_oe_o      <= 1'b0;
          state              <= S_WNXT;
        end
        S_WNXT: begin
          tmr_load <= 1'b1;
          case (step)
            2'h0: begin
              step  <= 2'h1;
              state <= S_WSEL;
            end
            2'h1: begin
              // program or erase runs while the host counts
              tmr_count <= (op == `FSEQ_OP_PROGRAM) ?
                           `FSEQ_TDP_CYC :
                           ERASE_CYCLES;
              state     <= S_OPW;
            end
            default: begin
              tmr_count <= `FSEQ_TWR_CYC;
              state     <= S_RCV;
            end
          endcase
        end
        S_OPW: begin
          // verify command ends the operation, never before the count
          if (tmr_done) begin
            step  <= 2'h2;
            state <= S_WSEL;
          end
        end
        S_RCV: begin
          if (tmr_done) begin
            // only the devices under verify drive their lanes
            device_selects_n_o <= fseq_sel_n(bank, lanes);
            output_en_n_o      <= 1'b0;
            tmr_load           <= 1'b1;
            tmr_count          <= `FSEQ_TACC_CYC;
            state              <= S_RACC;
          end
        end
        S_RACC: begin
          if (tmr_done) begin
            rdata_o            <= flash_dq_i;
            device_selects_n_o <= 4'hF;
            output_en_n_o      <= 1'b1;
            tmr_load           <= 1'b1;
            tmr_count          <= `FSEQ_TDF_CYC;
            state              <= S_RFLT;
          end
        end
        S_RFLT: begin
          // let the module float its outputs before the bus is reused
          if (tmr_done) begin
            vpp_high_o <= 1'b0;
            done_o     <= 1'b1;
            state      <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* fseq_defines.vh */
// timing counts and command bytes for the flash module write sequencer
`ifndef FSEQ_DEFINES_VH
`define FSEQ_DEFINES_VH

// ----------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------
`define FSEQ_CLK_NS          20

// ----------------------------------------------------------------------
// times as printed, each in its own unit
// ----------------------------------------------------------------------
`define FSEQ_TCS_NS          20
`define FSEQ_TWP_NS          80
`define FSEQ_TACC_NS         250
`define FSEQ_TDF_NS          60
`define FSEQ_SUPPLY_TO_SELECT_GAP_NS        1000
`define FSEQ_TWR_US          6
`define FSEQ_TDP_US          10
`define FSEQ_TDE_MIN_US      9500
`define FSEQ_TDE_MAX_US      10500

// ----------------------------------------------------------------------
// cycle counts: least times round up, longest times round down
// ----------------------------------------------------------------------
`define FSEQ_CEIL(ns)        (((ns) + `FSEQ_CLK_NS - 1) / `FSEQ_CLK_NS)
`define FSEQ_TWP_CYC         `FSEQ_CEIL(`FSEQ_TWP_NS)
`define FSEQ_TACC_CYC        `FSEQ_CEIL(`FSEQ_TACC_NS)
`define FSEQ_TDF_CYC         `FSEQ_CEIL(`FSEQ_TDF_NS)
`define FSEQ_SUPPLY_TO_SELECT_GAP_CYC       `FSEQ_CEIL(`FSEQ_SUPPLY_TO_SELECT_GAP_NS)
`define FSEQ_TWR_CYC         `FSEQ_CEIL(`FSEQ_TWR_US * 1000)
`define FSEQ_TDP_CYC         `FSEQ_CEIL(`FSEQ_TDP_US * 1000)
`define FSEQ_TDE_MIN_CYC     `FSEQ_CEIL(`FSEQ_TDE_MIN_US * 1000)
`define FSEQ_TDE_MAX_CYC     ((`FSEQ_TDE_MAX_US * 1000) / `FSEQ_CLK_NS)

// ----------------------------------------------------------------------
// user operations and command bytes
// ----------------------------------------------------------------------
`define FSEQ_OP_READ         2'h0
`define FSEQ_OP_PROGRAM      2'h1
`define FSEQ_OP_ERASE        2'h2
`define FSEQ_CMD_NULL        8'h00
`define FSEQ_CMD_PROG_SETUP  8'h40

`endif

/* fseq_timer.v */
// down-counting wait timer shared by every interval of the sequencer
`timescale 1ns/1ps

module fseq_timer #(
  parameter WIDTH = 20
) (
  input  wire             clk_i,
  input  wire             rst_n_i,
  input  wire             load_i,
  input  wire [WIDTH-1:0] count_i,
  output wire             zero_o
);

  reg [WIDTH-1:0] cnt;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  // load wins over the decrement so a new wait never inherits an old one
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= {WIDTH{1'b0}};
    end else if (load_i) begin
      cnt <= count_i;
    end else if (cnt != {WIDTH{1'b0}}) begin
      cnt <= cnt - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign zero_o = (cnt == {WIDTH{1'b0}});

endmodule

/* fseq_flash_model.sv */
// behavioural four-device flash module answering the host sequencer
`timescale 1ns/1ps
`include "fseq_defines.vh"

module fseq_flash_model #(
  parameter CMD_ERASE_SETUP = 8'h01,
  parameter CMD_ERASE_GO    = 8'h02
) (
  input  wire        mclk_i,
  input  wire [16:0] addr_i,
  input  wire [15:0] dq_i,
  output reg  [15:0] dq_o,
  input  wire [3:0]  sel_n_i,
  input  wire        we_n_i,
  input  wire        oe_n_i,
  input  wire        vpp_i
);
  reg     [7:0]  mem [0:63];
  reg     [7:0]  state [0:3];
  reg     [3:0]  wr_q;
  reg     [15:0] dq_q;
  integer        d;
  integer        k;

  // one byte reaches one device; each device keeps its own command state
  task commit(input integer n, input [7:0] b);
    begin
      if (state[n] == `FSEQ_CMD_PROG_SETUP) begin
        mem[{n[1:0], addr_i[3:0]}] = b;
        state[n] = 8'h00;
      end else if (state[n] == CMD_ERASE_SETUP && b == CMD_ERASE_GO) begin
        for (k = 0; k < 16; k = k + 1)
          mem[{n[1:0], k[3:0]}] = 8'hFF;
        state[n] = 8'h00;
      end else
        state[n] = b;
    end
  endtask

  // a lane shows its one enabled device; two drivers clash, none toggles
  function [7:0] lane(input h, input [7:0] last);
    reg a;
    reg b;
    begin
      a = !oe_n_i && !sel_n_i[{1'b0, h}];
      b = !oe_n_i && !sel_n_i[{1'b1, h}];
      if (a && b)
        lane = 8'hXX;
      else if (a || b)
        lane = mem[{b, h, addr_i[3:0]}];
      else
        lane = ~last;
    end
  endfunction

  initial begin
    for (k = 0; k < 64; k = k + 1)
      mem[k] = 8'hFF;
    for (d = 0; d < 4; d = d + 1)
      state[d] = 8'h00;
    wr_q = 4'h0;
    dq_o = 16'h0000;
  end

  // a write lands when the select and write-enable overlap ends
  always @(posedge mclk_i) begin
    for (d = 0; d < 4; d = d + 1) begin
      if (wr_q[d] && !(!sel_n_i[d] && !we_n_i) && vpp_i)
        commit(d, d[0] ? dq_q[15:8] : dq_q[7:0]);
      wr_q[d] <= !sel_n_i[d] && !we_n_i;
    end
    if (!we_n_i)
      dq_q <= dq_i;
    dq_o <= {lane(1'b1, dq_o[15:8]), lane(1'b0, dq_o[7:0])};
  end
endmodule

/* fseq_host_properties.sv */
// concurrent checks on the host sequencer ports
`timescale 1ns/1ps
`include "fseq_defines.vh"

module fseq_host_properties #(
  parameter ERASE_CYCLES    = 40,
  parameter CMD_ERASE_SETUP = 8'h01
) (
  input wire        mclk_i,
  input wire        resetn_i,
  input wire        cmd_valid_i,
  input wire [1:0]  cmd_op_i,
  input wire        cmd_bank_i,
  input wire [1:0]  cmd_lanes_i,
  input wire [15:0] cmd_data_i,
  input wire        cmd_ready_o,
  input wire        done_o,
  input wire [15:0] flash_dq_o,
  input wire        flash_dq_oe_o,
  input wire [3:0]  device_selects_n_o,
  input wire        write_en_n_o,
  input wire        output_en_n_o,
  input wire        vpp_high_o
);
  reg  [31:0] wcnt;
  reg  [15:0] vcnt;
  reg  [1:0]  widx;
  reg  [1:0]  op_q;
  reg  [1:0]  lanes_q;
  reg         bank_q;
  reg  [15:0] data_q;
  wire [7:0]  setup_b = op_q == `FSEQ_OP_PROGRAM ? `FSEQ_CMD_PROG_SETUP : CMD_ERASE_SETUP;
  wire [15:0] setup_w = {lanes_q[1] ? setup_b : 8'h00, lanes_q[0] ? setup_b : 8'h00};
  wire [3:0]  vsel = bank_q ? {~lanes_q, 2'b11} : {2'b11, ~lanes_q};

  // saturating gaps since the last write and since the supply went high
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wcnt <= 32'hFFFFFFFF;
      vcnt <= 16'h0000;
      widx <= 2'h0;
    end else begin
      wcnt <= !write_en_n_o ? 32'h00000000 : wcnt + {31'h00000000, wcnt != 32'hFFFFFFFF};
      vcnt <= !vpp_high_o ? 16'h0000 : vcnt + {15'h0000, vcnt != 16'hFFFF};
      if (cmd_valid_i && cmd_ready_o)
        widx <= 2'h0;
      else if ($rose(write_en_n_o) && widx != 2'h3)
        widx <= widx + 2'h1;
    end
  end

  // request fields held for the operation under way
  always @(posedge mclk_i) begin
    if (cmd_valid_i && cmd_ready_o) begin
      op_q    <= cmd_op_i;
      lanes_q <= cmd_lanes_i;
      bank_q  <= cmd_bank_i;
      data_q  <= cmd_data_i;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_take;
    cmd_valid_i && cmd_ready_o;
  endsequence
  sequence s_wr;
    $fell(write_en_n_o);
  endsequence

  chk_setup_lane_bytes: assert property (s_wr ##0 widx == 2'h0 |-> flash_dq_o == setup_w)
    else $error("setup command bytes wrong on the lanes");
  chk_data_word: assert property (s_wr ##0 (widx == 2'h1 && op_q == `FSEQ_OP_PROGRAM)
    |-> flash_dq_o == data_q)
    else $error("program data word wrong");
  chk_prog_duration: assert property (s_wr ##0 (widx == 2'h2 && op_q == `FSEQ_OP_PROGRAM)
    |-> wcnt >= `FSEQ_TDP_CYC)
    else $error("program ended too early");
  chk_erase_window: assert property (s_wr ##0 (widx == 2'h2 && op_q[1])
    |-> wcnt >= ERASE_CYCLES && wcnt <= ERASE_CYCLES * 21 / 19)
    else $error("erase duration out of range");
  chk_write_recovery: assert property ($fell(output_en_n_o) |-> wcnt >= `FSEQ_TWR_CYC)
    else $error("read started too soon after a write");
  chk_supply_lead: assert property ($past(&device_selects_n_o) && !(&device_selects_n_o)
    && vpp_high_o |-> vcnt >= `FSEQ_SUPPLY_TO_SELECT_GAP_CYC)
    else $error("select fell too soon after supply rise");
  chk_write_supply: assert property (s_wr |-> vpp_high_o && $stable(device_selects_n_o))
    else $error("write without supply or steady selects");
  chk_write_release: assert property ($rose(write_en_n_o) |-> device_selects_n_o != 4'hF
    && flash_dq_oe_o)
    else $error("selects or data released with write enable");
  chk_verify_select: assert property (!output_en_n_o |-> device_selects_n_o == vsel
    && write_en_n_o)
    else $error("untargeted device enabled during a read");
  chk_read_answer: assert property (s_take ##0 cmd_op_i == `FSEQ_OP_READ
    |=> !cmd_ready_o ##[13:40] done_o)
    else $error("read not answered in time");
endmodule

/* test_flash_module_write_sequencer.sv */
// self-checking bench for the flash module host sequencer
`timescale 1ns/1ps
`include "fseq_defines.vh"
`define CHECK(got, exp) \
  begin \
    check_count = check_count + 1; \
    if ((got) !== (exp)) begin \
      err_count = err_count + 1; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_flash_module_write_sequencer;
  reg         mclk;
  reg         resetn;
  reg         cmd_valid;
  reg  [1:0]  cmd_op;
  reg         cmd_bank;
  reg  [1:0]  cmd_lanes;
  reg  [16:0] cmd_addr;
  reg  [15:0] cmd_data;
  wire        cmd_ready;
  wire        done;
  wire [15:0] rdata;
  wire [16:0] faddr;
  wire [15:0] host_dq;
  wire        host_oe;
  wire [15:0] mod_dq;
  wire [3:0]  sel_n;
  wire        we_n;
  wire        oe_n;
  wire        vpp;
  wire [15:0] bus = host_oe ? host_dq : mod_dq;
  integer     err_count = 0;
  integer     check_count = 0;

  fseq_host #(.ERASE_CYCLES(400)) i_fseq_host (
    .mclk_i(mclk), .resetn_i(resetn), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
    .cmd_bank_i(cmd_bank), .cmd_lanes_i(cmd_lanes), .cmd_addr_i(cmd_addr),
    .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready), .done_o(done), .rdata_o(rdata),
    .flash_addr_o(faddr), .flash_dq_o(host_dq), .flash_dq_oe_o(host_oe),
    .flash_dq_i(bus), .device_selects_n_o(sel_n), .write_en_n_o(we_n),
    .output_en_n_o(oe_n), .vpp_high_o(vpp));

  fseq_flash_model i_fseq_flash_model (
    .mclk_i(mclk), .addr_i(faddr), .dq_i(bus), .dq_o(mod_dq), .sel_n_i(sel_n),
    .we_n_i(we_n), .oe_n_i(oe_n), .vpp_i(vpp));

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // one request, bounded waits for ready and for done
  task run_op(input [1:0] op, input bank, input [1:0] lanes, input [16:0] a,
              input [15:0] data);
    integer n;
    begin
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
        @(negedge mclk);
        n = n + 1;
      end
      if (n == 100)
        err_count = err_count + 1;
      cmd_op = op;
      cmd_bank = bank;
      cmd_lanes = lanes;
      cmd_addr = a;
      cmd_data = data;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
        @(negedge mclk);
        n = n + 1;
      end
      if (n == 3000)
        err_count = err_count + 1;
    end
  endtask

  task t_read_erased;
    begin
      run_op(`FSEQ_OP_READ, 1'b0, 2'b11, 17'h00005, 16'h0000);
      `CHECK(rdata, 16'hFFFF)
    end
  endtask

  // word program then an immediate read back
  task t_prog_word;
    begin
      run_op(`FSEQ_OP_PROGRAM, 1'b0, 2'b11, 17'h00003, 16'hA55A);
      `CHECK(rdata, 16'hA55A)
      `CHECK(faddr, 17'h00003)
      run_op(`FSEQ_OP_READ, 1'b0, 2'b11, 17'h00003, 16'h0000);
      `CHECK(rdata, 16'hA55A)
    end
  endtask

  // low device of the upper pair only; its partner must stay erased
  task t_prog_single;
    begin
      run_op(`FSEQ_OP_PROGRAM, 1'b1, 2'b01, 17'h00003, 16'h1234);
      `CHECK(rdata[7:0], 8'h34)
      run_op(`FSEQ_OP_READ, 1'b1, 2'b11, 17'h00003, 16'h0000);
      `CHECK(rdata, 16'hFF34)
    end
  endtask

  // erase the high device of the lower pair; the low byte survives
  task t_erase_lane;
    begin
      run_op(`FSEQ_OP_ERASE, 1'b0, 2'b10, 17'h00000, 16'h0000);
      `CHECK(rdata[15:8], 8'hFF)
      run_op(`FSEQ_OP_READ, 1'b0, 2'b11, 17'h00003, 16'h0000);
      `CHECK(rdata, 16'hFF5A)
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #400000;
    err_count = err_count + 1;
    finish_test;
  end

  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_bank = 1'b0;
    cmd_lanes = 2'h0;
    cmd_addr = 17'h00000;
    cmd_data = 16'h0000;
    repeat (6) @(negedge mclk);
    `CHECK({sel_n, we_n, oe_n, vpp, cmd_ready}, 8'hFC)
    resetn = 1'b1;
    t_read_erased;
    t_prog_word;
    t_prog_single;
    t_erase_lane;
    finish_test;
  end
endmodule

bind fseq_host fseq_host_properties #(
  .ERASE_CYCLES(ERASE_CYCLES), .CMD_ERASE_SETUP(CMD_ERASE_SETUP)
) i_fseq_host_properties (
  .mclk_i, .resetn_i, .cmd_valid_i, .cmd_op_i, .cmd_bank_i, .cmd_lanes_i, .cmd_data_i,
  .cmd_ready_o, .done_o, .flash_dq_o, .flash_dq_oe_o, .device_selects_n_o,
  .write_en_n_o, .output_en_n_o, .vpp_high_o);
